// >>> rtl/cma_pkg.sv
// Shared constants and types for the card memory access host controller
package cma_pkg;

  // ----------------------------------------
  // Clock and pin timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS      = 8;
  localparam int T_ADDR_SETUP_NS    = 30;   // Address and enables to strobe low
  localparam int T_WRITE_PULSE_NS   = 150;  // Least write strobe width
  localparam int T_READ_ACCESS_NS   = 250;  // Card enable access time
  localparam int T_HOLD_NS          = 30;   // Address and data hold after strobe
  localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPULSE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC = (T_READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 8;

  // ----------------------------------------
  // Pin levels and lane layout
  // ----------------------------------------
  localparam logic       PIN_ACTIVE   = 1'h0;
  localparam logic       PIN_INACTIVE = 1'h1;
  localparam int         LANE_W       = 8;
  localparam logic [1:0] LANES_NONE   = 2'h0;
  localparam logic [1:0] LANE_LO      = 2'h1;
  localparam logic [1:0] LANE_HI      = 2'h2;
  localparam logic [1:0] LANES_BOTH   = 2'h3;

  // Lane mode of one access
  typedef enum logic [1:0] {
    CMA_BYTE,
    CMA_WORD,
    CMA_ODD
  } cma_lane_e;

  // Outcome of one access
  typedef enum logic [1:0] {
    CMA_OK,
    CMA_PROTECTED,
    CMA_NO_TRANSFER
  } cma_stat_e;

endpackage

// >>> rtl/cma_tmr_if.sv
// Phase timer hand-off between the access sequencer and its counter
`timescale 1ns/1ns
`default_nettype none
interface cma_tmr_if;
  import cma_pkg::*;

  logic             load;     // Start a phase
  logic [CNT_W-1:0] count;    // Phase length in cycles
  logic             expired;  // Phase over

  modport ctrl (output load, output count, input expired);
  modport tmr  (input load, input count, output expired);
endinterface
`default_nettype wire

// >>> rtl/cma_phase_timer.sv
// Down counter that times each phase of a card access
`timescale 1ns/1ns
`default_nettype none
module cma_phase_timer (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // Sequencer side
  cma_tmr_if.tmr    tmr
);
  import cma_pkg::*;

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // Next count: load takes the first cycle of the phase
  always_comb begin
    cnt_nxt = cnt_r;
    if (tmr.load) begin
      cnt_nxt = tmr.count - CNT_W'(1);
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  // Count register
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Phase over at zero; load is left out so the sequencer cannot loop back on it
  assign tmr.expired = (cnt_r == '0);
endmodule
`default_nettype wire

// >>> rtl/cma_host_ctrl.sv
// Host controller that runs common and attribute memory cycles on a card
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Select, enables, lsb mean same on writes
// - Common write: output enable high, strobe low
// - Attribute read: select and OE held low
// - Attribute write: select, strobe low, OE high
module cma_host_ctrl #(
  parameter int ADDR_W = 26
) (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset,
  // Request from the user
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               req_write,
  input  wire logic               req_attr,
  input  wire cma_pkg::cma_lane_e req_lane,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [15:0]        req_wdata,
  // Answer to the user
  output logic                    rsp_valid,
  output cma_pkg::cma_stat_e      rsp_status,
  output logic [15:0]             rsp_rdata,
  // Writability regions read from the card description table
  input  wire logic               always_region_en,
  input  wire logic [ADDR_W-1:0]  always_region_lo,
  input  wire logic [ADDR_W-1:0]  always_region_hi,
  input  wire logic               never_region_en,
  input  wire logic [ADDR_W-1:0]  never_region_lo,
  input  wire logic [ADDR_W-1:0]  never_region_hi,
  // Card pins
  output logic [ADDR_W-1:1]       card_addr,
  output logic                    byte_address_lsb,
  output logic                    attr_space_n,
  output logic                    low_lane_card_enable_n,
  output logic                    high_lane_card_enable_n,
  output logic                    output_enable_n,
  output logic                    write_strobe_n,
  input  wire logic               card_write_protect,
  input  wire logic [15:0]        card_data_in,
  output logic [15:0]             card_data_out,
  output logic                    card_data_oe
);
  import cma_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (ADDR_W < 2 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 2 and 32");
  end

  // ----------------------------------------
  // Lane decoding
  // ----------------------------------------
  // Lanes that carry a valid byte for a mode, space and lsb
  function automatic logic [1:0] lanes_used(cma_lane_e mode, logic attr, logic lsb);
    logic [1:0] l;
    l = LANES_NONE;
    case (mode)
      CMA_BYTE: l = LANE_LO;
      CMA_WORD: l = LANES_BOTH;
      CMA_ODD:  l = LANE_HI;
      default:  l = LANES_NONE;
    endcase
    if (attr) begin
      if (mode == CMA_ODD || (mode == CMA_BYTE && lsb)) begin
        l = LANES_NONE;
      end else begin
        l = LANE_LO;
      end
    end
    return l;
  endfunction

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD
  } cma_state_e;

  cma_tmr_if tmr_bus ();

  cma_phase_timer u_timer (
    .sys_clk (sys_clk),
    .reset   (reset),
    .tmr     (tmr_bus.tmr)
  );

  cma_state_e         state_r, state_nxt;
  logic               write_r, write_nxt;
  logic [1:0]         lanes_r, lanes_nxt;
  logic               rsp_valid_r, rsp_valid_nxt;
  cma_stat_e          rsp_status_r, rsp_status_nxt;
  logic [15:0]        rsp_rdata_r, rsp_rdata_nxt;
  logic [ADDR_W-1:1]  addr_r, addr_nxt;
  logic               lsb_r, lsb_nxt;
  logic               attr_n_r, attr_n_nxt;
  logic               ce_lo_n_r, ce_lo_n_nxt;
  logic               ce_hi_n_r, ce_hi_n_nxt;
  logic               oe_n_r, oe_n_nxt;
  logic               we_n_r, we_n_nxt;
  logic [15:0]        dout_r, dout_nxt;
  logic               doe_r, doe_nxt;

  logic               in_always;
  logic               in_never;
  logic               protect_eff;
  logic [1:0]         req_lanes;

  // Effective protection of the requested address
  assign in_always = always_region_en && req_addr >= always_region_lo
                     && req_addr <= always_region_hi;
  assign in_never  = never_region_en && req_addr >= never_region_lo
                     && req_addr <= never_region_hi;
  assign protect_eff = in_never ? 1'h1 : (in_always ? 1'h0 : card_write_protect);
  assign req_lanes   = lanes_used(req_lane, req_attr, req_addr[0]);

  // Next values of the sequencer and the card pins
  always_comb begin
    state_nxt      = state_r;
    write_nxt      = write_r;
    lanes_nxt      = lanes_r;
    rsp_valid_nxt  = 1'h0;
    rsp_status_nxt = rsp_status_r;
    rsp_rdata_nxt  = rsp_rdata_r;
    addr_nxt       = addr_r;
    lsb_nxt        = lsb_r;
    attr_n_nxt     = attr_n_r;
    ce_lo_n_nxt    = ce_lo_n_r;
    ce_hi_n_nxt    = ce_hi_n_r;
    oe_n_nxt       = oe_n_r;
    we_n_nxt       = we_n_r;
    dout_nxt       = dout_r;
    doe_nxt        = doe_r;
    tmr_bus.load   = 1'h0;
    tmr_bus.count  = CNT_W'(SETUP_CYC);
    case (state_r)
      ST_IDLE: begin
        if (req_valid) begin
          write_nxt = req_write;
          lanes_nxt = req_lanes;
          if (req_write && protect_eff) begin
            rsp_valid_nxt  = 1'h1;
            rsp_status_nxt = CMA_PROTECTED;
            rsp_rdata_nxt  = 16'h0000;
          end else if (req_lanes == LANES_NONE) begin
            rsp_valid_nxt  = 1'h1;
            rsp_status_nxt = CMA_NO_TRANSFER;
            rsp_rdata_nxt  = 16'h0000;
          end else begin
            state_nxt    = ST_SETUP;
            tmr_bus.load = 1'h1;
            addr_nxt     = req_addr[ADDR_W-1:1];
            lsb_nxt      = (req_lane == CMA_BYTE) ? req_addr[0] : 1'h0;
            attr_n_nxt   = req_attr ? PIN_ACTIVE : PIN_INACTIVE;
            ce_lo_n_nxt  = (req_lane == CMA_ODD) ? PIN_INACTIVE : PIN_ACTIVE;
            ce_hi_n_nxt  = (req_lane == CMA_BYTE) ? PIN_INACTIVE : PIN_ACTIVE;
            // place write bytes on their lanes
            dout_nxt     = 16'h0000;
            if (req_lanes[0]) begin
              dout_nxt[LANE_W-1:0] = req_wdata[LANE_W-1:0];
            end
            if (req_lanes[1]) begin
              dout_nxt[15:LANE_W] = req_wdata[15:LANE_W];
            end
            // host alone drives lanes on writes
            doe_nxt      = req_write;
          end
        end
      end
      ST_SETUP: begin
        if (tmr_bus.expired) begin
          state_nxt     = ST_STROBE;
          tmr_bus.load  = 1'h1;
          tmr_bus.count = write_r ? CNT_W'(WPULSE_CYC) : CNT_W'(ACCESS_CYC);
          // write keeps OE high, strobe low
          we_n_nxt      = write_r ? PIN_ACTIVE : PIN_INACTIVE;
          oe_n_nxt      = write_r ? PIN_INACTIVE : PIN_ACTIVE;
        end
      end
      ST_STROBE: begin
        if (tmr_bus.expired) begin
          state_nxt     = ST_HOLD;
          tmr_bus.load  = 1'h1;
          tmr_bus.count = CNT_W'(HOLD_CYC);
          we_n_nxt      = PIN_INACTIVE;
          oe_n_nxt      = PIN_INACTIVE;
          if (!write_r) begin
            rsp_rdata_nxt = 16'h0000;
            if (lanes_r[0]) begin
              rsp_rdata_nxt[LANE_W-1:0] = card_data_in[LANE_W-1:0];
            end
            if (lanes_r[1]) begin
              rsp_rdata_nxt[15:LANE_W] = card_data_in[15:LANE_W];
            end
          end else begin
            rsp_rdata_nxt = 16'h0000;
          end
        end
      end
      ST_HOLD: begin
        if (tmr_bus.expired) begin
          state_nxt      = ST_IDLE;
          ce_lo_n_nxt    = PIN_INACTIVE;
          ce_hi_n_nxt    = PIN_INACTIVE;
          attr_n_nxt     = PIN_INACTIVE;
          doe_nxt        = 1'h0;
          rsp_valid_nxt  = 1'h1;
          rsp_status_nxt = CMA_OK;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_r      <= ST_IDLE;
      write_r      <= 1'h0;
      lanes_r      <= LANES_NONE;
      rsp_valid_r  <= 1'h0;
      rsp_status_r <= CMA_OK;
      rsp_rdata_r  <= 16'h0000;
      addr_r       <= '0;
      lsb_r        <= 1'h0;
      attr_n_r     <= PIN_INACTIVE;
      ce_lo_n_r    <= PIN_INACTIVE;
      ce_hi_n_r    <= PIN_INACTIVE;
      oe_n_r       <= PIN_INACTIVE;
      we_n_r       <= PIN_INACTIVE;
      dout_r       <= 16'h0000;
      doe_r        <= 1'h0;
    end else begin
      state_r      <= state_nxt;
      write_r      <= write_nxt;
      lanes_r      <= lanes_nxt;
      rsp_valid_r  <= rsp_valid_nxt;
      rsp_status_r <= rsp_status_nxt;
      rsp_rdata_r  <= rsp_rdata_nxt;
      addr_r       <= addr_nxt;
      lsb_r        <= lsb_nxt;
      attr_n_r     <= attr_n_nxt;
      ce_lo_n_r    <= ce_lo_n_nxt;
      ce_hi_n_r    <= ce_hi_n_nxt;
      oe_n_r       <= oe_n_nxt;
      we_n_r       <= we_n_nxt;
      dout_r       <= dout_nxt;
      doe_r        <= doe_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign req_ready               = (state_r == ST_IDLE);
  assign rsp_valid               = rsp_valid_r;
  assign rsp_status              = rsp_status_r;
  assign rsp_rdata               = rsp_rdata_r;
  assign card_addr               = addr_r;
  assign byte_address_lsb        = lsb_r;
  assign attr_space_n            = attr_n_r;
  assign low_lane_card_enable_n  = ce_lo_n_r;
  assign high_lane_card_enable_n = ce_hi_n_r;
  assign output_enable_n         = oe_n_r;
  assign write_strobe_n          = we_n_r;
  assign card_data_out           = dout_r;
  assign card_data_oe            = doe_r;
endmodule
`default_nettype wire

// >>> verif/cma_card_model.sv
// Behavioural memory card answering the host controller's pins
`timescale 1ns/1ns
`default_nettype none
module cma_card_model #(
  parameter int AW = 8
) (
  // Clock for the floating-lane pattern
  input  wire logic          sys_clk,
  // Card pins
  input  wire logic [AW-1:1] card_addr,
  input  wire logic          byte_address_lsb,
  input  wire logic          attr_space_n,
  input  wire logic          low_lane_card_enable_n,
  input  wire logic          high_lane_card_enable_n,
  input  wire logic          output_enable_n,
  input  wire logic          write_strobe_n,
  input  wire logic [15:0]   bus_lanes,
  output logic               card_write_protect,
  output logic [15:0]        card_lanes,
  // Protect switch and listed regions
  input  wire logic          wp_sw,
  input  wire logic          aw_en,
  input  wire logic          nw_en,
  input  wire logic [AW-1:0] aw_lo,
  input  wire logic [AW-1:0] aw_hi,
  input  wire logic [AW-1:0] nw_lo,
  input  wire logic [AW-1:0] nw_hi
);
  logic [7:0]    cm [2**AW];
  logic [7:0]    am [2**AW];
  logic [7:0]    pat = 8'h5A;
  logic [AW-1:0] ev, ba;
  logic          lo, hi, prot;
  assign ev = {card_addr, 1'b0};
  assign lo = !low_lane_card_enable_n;
  assign hi = !high_lane_card_enable_n;
  // Lsb picks the byte only when the low lane works alone
  assign ba = ev | AW'(byte_address_lsb && !hi);
  assign card_write_protect = wp_sw;
  // Listed regions ignore the pin, never-writable wins
  assign prot = (nw_en && ba >= nw_lo && ba <= nw_hi) ||
                (wp_sw && !(aw_en && ba >= aw_lo && ba <= aw_hi));
  // Floating lanes change every cycle
  always @(posedge sys_clk) begin
    pat <= pat + 8'h3B;
  end
  // Drive only valid read lanes, others float
  always_comb begin
    card_lanes = {~pat, pat};
    if (!output_enable_n && lo)
      card_lanes[7:0] = attr_space_n ? cm[ba] : (ba[0] ? pat : am[ev]);
    if (!output_enable_n && hi && attr_space_n)
      card_lanes[15:8] = cm[ev | AW'(1)];
  end
  // Latch the lanes as the strobe ends
  always @(posedge write_strobe_n) begin
    if (lo && !prot && attr_space_n)
      cm[ba] <= bus_lanes[7:0];
    if (lo && !prot && !attr_space_n && !ba[0])
      am[ev] <= bus_lanes[7:0];
    if (hi && !prot && attr_space_n)
      cm[ev | AW'(1)] <= bus_lanes[15:8];
  end
endmodule
`default_nettype wire

// >>> verif/cma_host_ctrl_chk.sv
// Pin-level checks for the card memory host controller
`timescale 1ns/1ns
`default_nettype none
module cma_host_ctrl_chk #(
  parameter int ADDR_W = 26
) (
  // Clock and reset
  input wire logic               sys_clk,
  input wire logic               reset,
  // User side
  input wire logic               req_valid,
  input wire logic               req_ready,
  input wire logic               req_write,
  input wire logic               req_attr,
  input wire cma_pkg::cma_lane_e req_lane,
  input wire logic [ADDR_W-1:0]  req_addr,
  input wire logic               rsp_valid,
  input wire cma_pkg::cma_stat_e rsp_status,
  input wire logic               always_region_en,
  // Card pins
  input wire logic               byte_address_lsb,
  input wire logic               attr_space_n,
  input wire logic               low_lane_card_enable_n,
  input wire logic               high_lane_card_enable_n,
  input wire logic               output_enable_n,
  input wire logic               write_strobe_n,
  input wire logic               card_write_protect,
  input wire logic [15:0]        card_data_out,
  input wire logic               card_data_oe
);
  import cma_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Idle host keeps card in standby
  a_idle_standby: assert property (req_ready |-> low_lane_card_enable_n &&
    high_lane_card_enable_n && output_enable_n && write_strobe_n) else $error("card not idle");
  // Write strobe only with output enable off
  a_write_oe_off: assert property (!write_strobe_n |->
    output_enable_n && card_data_oe) else $error("write with output enable");
  a_read_sel_held: assert property (!output_enable_n |=>
    output_enable_n || $stable(attr_space_n)) else $error("select moved in read");
  // Select and data held through a write
  a_write_held: assert property (!write_strobe_n |=> write_strobe_n ||
    $stable({attr_space_n, card_data_out})) else $error("select moved in write");
  // Lsb low whenever the high lane works
  a_word_lsb_low: assert property (!high_lane_card_enable_n |->
    !byte_address_lsb) else $error("lsb set in word or odd mode");
  // Attribute cycles use even low byte only
  a_attr_even: assert property (!attr_space_n && !low_lane_card_enable_n |->
    !byte_address_lsb) else $error("odd attribute access");
  // Odd attribute requests refused next cycle
  a_attr_refuse: assert property (req_valid && req_ready && req_attr &&
    (req_lane == CMA_ODD || (req_lane == CMA_BYTE && req_addr[0]))
    |=> rsp_valid && rsp_status == CMA_NO_TRANSFER) else $error("odd attribute taken");
  // Protected common write refused next cycle
  a_prot_refuse: assert property (req_valid && req_ready && req_write && !req_attr &&
    card_write_protect && !always_region_en |=> rsp_valid && rsp_status == CMA_PROTECTED)
    else $error("protected write taken");
  c_ok: cover property (rsp_valid && rsp_status == CMA_OK);
  c_prot: cover property (rsp_valid && rsp_status == CMA_PROTECTED);
  c_none: cover property (rsp_valid && rsp_status == CMA_NO_TRANSFER);
endmodule
bind cma_host_ctrl cma_host_ctrl_chk #(.ADDR_W(ADDR_W)) u_chk (.sys_clk, .reset,
  .req_valid, .req_ready, .req_write, .req_attr, .req_lane, .req_addr, .rsp_valid,
  .rsp_status, .always_region_en, .byte_address_lsb, .attr_space_n, .low_lane_card_enable_n,
  .high_lane_card_enable_n, .output_enable_n, .write_strobe_n, .card_write_protect,
  .card_data_out, .card_data_oe);
`default_nettype wire

// >>> verif/tb_cma_host_ctrl.sv
// Self-checking bench for the card memory host controller
`timescale 1ns/1ns
`default_nettype none
module tb_cma_host_ctrl;
  import cma_pkg::*;
  localparam int AW = 8;
  localparam int LR = 41;  // Read: take to answer
  localparam int LW = 28;  // Write: take to answer
  localparam int LF = 1;   // Refusal
  localparam logic [1:0] RC = 2'h0, RA = 2'h1, WC = 2'h2, WA = 2'h3;
  logic          sys_clk = 1'b0, reset = 1'b1, req_valid = 1'b0;
  logic          req_write = 1'b0, req_attr = 1'b0;
  cma_lane_e     req_lane = CMA_BYTE;
  logic [AW-1:0] req_addr = 8'h00;
  logic [15:0]   req_wdata = 16'h0000;
  logic          wp_sw = 1'b0, aw_en = 1'b0, nw_en = 1'b0;
  logic [AW-1:0] aw_lo = 8'h00, aw_hi = 8'h00, nw_lo = 8'h00, nw_hi = 8'h00;
  logic          req_ready, rsp_valid, byte_address_lsb, attr_space_n, card_data_oe;
  logic          low_lane_card_enable_n, high_lane_card_enable_n, output_enable_n;
  logic          write_strobe_n, card_write_protect;
  cma_stat_e     rsp_status;
  logic [15:0]   rsp_rdata, card_data_in, card_data_out, card_lanes;
  logic [AW-1:1] card_addr;
  int            n_mismatch = 0, comparisons = 0, cycles = 0;
  // Lanes: host drives while enabled, else the card
  assign card_data_in = card_data_oe ? card_data_out : card_lanes;
  cma_host_ctrl #(.ADDR_W(AW)) dut_u (.sys_clk, .reset, .req_valid, .req_ready,
    .req_write, .req_attr, .req_lane, .req_addr, .req_wdata, .rsp_valid, .rsp_status,
    .rsp_rdata, .always_region_en(aw_en), .always_region_lo(aw_lo),
    .always_region_hi(aw_hi), .never_region_en(nw_en), .never_region_lo(nw_lo),
    .never_region_hi(nw_hi), .card_addr, .byte_address_lsb, .attr_space_n,
    .low_lane_card_enable_n, .high_lane_card_enable_n, .output_enable_n, .write_strobe_n,
    .card_write_protect, .card_data_in, .card_data_out, .card_data_oe);
  cma_card_model #(.AW(AW)) card_u (.sys_clk, .card_addr, .byte_address_lsb,
    .attr_space_n, .low_lane_card_enable_n, .high_lane_card_enable_n, .output_enable_n,
    .write_strobe_n, .bus_lanes(card_data_in), .card_write_protect, .card_lanes,
    .wp_sw, .aw_en, .nw_en, .aw_lo, .aw_hi, .nw_lo, .nw_hi);
  // Clock
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One request; judges latency, status and read data
  task automatic op(input logic [1:0] wa, input cma_lane_e ln, input logic [7:0] ad,
      input logic [15:0] wd, input int lat, input cma_stat_e st, input logic [15:0] rd);
    int n;
    n = 1;
    @(negedge sys_clk);
    chk(16'({req_ready, low_lane_card_enable_n, high_lane_card_enable_n, output_enable_n,
      write_strobe_n, attr_space_n, card_data_oe}), 16'h007E);
    req_valid = 1'b1;
    req_lane = ln;
    {req_write, req_attr, req_addr, req_wdata} = {wa, ad, wd};
    @(negedge sys_clk);
    req_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk(16'(n), 16'(lat));
    chk(16'(rsp_status), 16'(st));
    chk(rsp_rdata, rd);
  endtask
  task automatic t_common();
    op(WC, CMA_WORD, 8'h10, 16'hA55A, LW, CMA_OK, 16'h0000);
    op(WC, CMA_BYTE, 8'h12, 16'h003C, LW, CMA_OK, 16'h0000);
    op(WC, CMA_BYTE, 8'h11, 16'h00EE, LW, CMA_OK, 16'h0000);
    op(WC, CMA_ODD, 8'h13, 16'h9600, LW, CMA_OK, 16'h0000);
    op(RC, CMA_WORD, 8'h11, 16'h0000, LR, CMA_OK, 16'hEE5A);
    op(RC, CMA_WORD, 8'h12, 16'h0000, LR, CMA_OK, 16'h963C);
    op(RC, CMA_BYTE, 8'h11, 16'h0000, LR, CMA_OK, 16'h00EE);
    op(RC, CMA_ODD, 8'h12, 16'h0000, LR, CMA_OK, 16'h9600);
    $display("t_common done");
  endtask
  task automatic t_attr();
    op(WA, CMA_BYTE, 8'h10, 16'h0077, LW, CMA_OK, 16'h0000);
    op(WA, CMA_WORD, 8'h12, 16'h8844, LW, CMA_OK, 16'h0000);
    op(WA, CMA_BYTE, 8'h11, 16'hFFFF, LF, CMA_NO_TRANSFER, 16'h0000);
    op(WA, CMA_ODD, 8'h12, 16'hFFFF, LF, CMA_NO_TRANSFER, 16'h0000);
    op(RA, CMA_WORD, 8'h12, 16'h0000, LR, CMA_OK, 16'h0044);
    op(RA, CMA_BYTE, 8'h10, 16'h0000, LR, CMA_OK, 16'h0077);
    op(RA, CMA_BYTE, 8'h11, 16'h0000, LF, CMA_NO_TRANSFER, 16'h0000);
    op(RA, CMA_ODD, 8'h12, 16'h0000, LF, CMA_NO_TRANSFER, 16'h0000);
    op(RC, CMA_WORD, 8'h10, 16'h0000, LR, CMA_OK, 16'hEE5A);
    $display("t_attr done");
  endtask
  task automatic t_protect();
    wp_sw = 1'b1;
    op(WC, CMA_WORD, 8'h10, 16'h1111, LF, CMA_PROTECTED, 16'h0000);
    op(RC, CMA_WORD, 8'h10, 16'h0000, LR, CMA_OK, 16'hEE5A);
    {aw_en, aw_lo, aw_hi} = {1'b1, 8'h10, 8'h1F};
    op(WC, CMA_WORD, 8'h10, 16'h1234, LW, CMA_OK, 16'h0000);
    op(WC, CMA_WORD, 8'h30, 16'h5678, LF, CMA_PROTECTED, 16'h0000);
    {nw_en, nw_lo, nw_hi, wp_sw} = {1'b1, 8'h12, 8'h13, 1'b0};
    op(WC, CMA_WORD, 8'h12, 16'h4321, LF, CMA_PROTECTED, 16'h0000);
    op(WC, CMA_WORD, 8'h30, 16'hBEEF, LW, CMA_OK, 16'h0000);
    op(RC, CMA_WORD, 8'h10, 16'h0000, LR, CMA_OK, 16'h1234);
    op(RC, CMA_WORD, 8'h12, 16'h0000, LR, CMA_OK, 16'h963C);
    op(RC, CMA_WORD, 8'h30, 16'h0000, LR, CMA_OK, 16'hBEEF);
    $display("t_protect done");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    reset = 1'b0;
    t_common();
    t_attr();
    t_protect();
    close_out();
  end
endmodule
`default_nettype wire
